// ---- logic/osd_pkg.sv ----
`default_nettype none
package osd_pkg;
  // rate thresholds in samples per second
  localparam logic [17:0] R100 = 18'h00064;
  localparam logic [17:0] R200 = 18'h000c8;
  localparam logic [17:0] R400 = 18'h00190;
  localparam logic [17:0] R800 = 18'h00320;
  localparam logic [17:0] R1000 = 18'h003e8;
  localparam logic [17:0] R1600 = 18'h00640;
  localparam logic [17:0] R3200 = 18'h00c80;
  localparam logic [17:0] R6400 = 18'h01900;
  localparam logic [17:0] R12800 = 18'h03200;
  localparam logic [17:0] R25600 = 18'h06400;
  localparam logic [17:0] R51200 = 18'h0c800;
  localparam logic [17:0] R102400 = 18'h19000;
  localparam logic [17:0] R204800 = 18'h32000;
  // modulator oversampling ratios
  localparam logic [7:0] OSR_32 = 8'h20;
  localparam logic [7:0] OSR_64 = 8'h40;
  localparam logic [7:0] OSR_128 = 8'h80;
  // decimation factor as log2
  localparam logic [3:0] SH_256 = 4'h8;
  localparam logic [3:0] SH_128 = 4'h7;
  localparam logic [3:0] SH_64 = 4'h6;
  localparam logic [3:0] SH_32 = 4'h5;
  localparam logic [3:0] SH_16 = 4'h4;
  localparam logic [3:0] SH_8 = 4'h3;
  localparam logic [3:0] SH_4 = 4'h2;
  localparam logic [3:0] SH_2 = 4'h1;
  localparam logic [3:0] SH_1 = 4'h0;
  // input filter latency in output samples
  localparam logic [31:0] FLT_DLY = 32'h0000003f;
  typedef enum logic [1:0] {
    REQ_ANY = 2'b00,
    REQ_HALF = 2'b01,
    REQ_NEAR = 2'b10
  } osd_req_e;
  localparam osd_req_e REQ_RST = REQ_ANY;
  typedef enum logic {
    OSD_IDLE = 1'b0,
    OSD_RUN = 1'b1
  } osd_run_e;
endpackage
`default_nettype wire

// ---- logic/osd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - digital lowpass passband edge follows half the output rate
// - above 102.4 up to 204.8 kS/s modulator runs at 32x
// - above 51.2 up to 102.4 kS/s modulator runs at 64x
// - up to 51.2 kS/s modulator runs at 128x
// - serial variant uses fixed 64x ratio at every rate
// - each unrejected band is one output rate wide
// - guard enabled in low band runs conversion at integer multiple
// - with guard active internal rate stays within 25.6 to 51.2 kS/s
// - decimate by the same multiple, delivering the requested rate
// - factors 256, 128, 64, 32 for 100 S/s to 1.6 kS/s
// - factors 16, 8, 4, 2 for 1.6 to 25.6 kS/s
// - guard enable reset default depends on device family
// - trigger start index is moved earlier by the filter delay
// - all input channels share one input FIFO
// - all output channels share one separate output FIFO
// - DMA request raised while the selected FIFO condition holds
// - serial variant keeps a fixed request condition, ignores writes
module osd_top #(
  parameter int N_CH = 4,
  parameter int DW = 24,
  parameter int DEPTH = 16,
  parameter bit SERIAL = 1'b0,
  parameter bit GUARD_DEF = 1'b1,
  parameter logic [31:0] FLT_DLY = osd_pkg::FLT_DLY
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [17:0] i_rate,
  input wire logic i_guard_wr,
  input wire logic i_guard_en,
  input wire logic i_req_cond_wr,
  input wire logic [1:0] i_req_cond,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_trig,
  input wire logic i_mod_valid,
  input wire logic [N_CH*DW-1:0] i_mod_data,
  output logic [7:0] o_mod_ratio,
  output logic [8:0] o_dec_factor,
  output logic [25:0] o_conv_rate,
  output logic [16:0] o_passband_hz,
  output logic [17:0] o_alias_band_hz,
  output logic o_guard_active,
  output logic o_low_rate_alias_guard_enable,
  output logic o_dec_valid,
  output logic [N_CH*DW-1:0] o_dec_data,
  output logic o_trig_seen,
  output logic [31:0] o_trig_start,
  output logic o_in_valid,
  output logic [N_CH*DW-1:0] o_in_data,
  input wire logic i_in_ready,
  output logic o_in_dma_req,
  output logic o_in_overflow,
  input wire logic i_out_valid,
  input wire logic [N_CH*DW-1:0] i_out_data,
  output logic o_out_ready,
  input wire logic i_out_tick,
  output logic o_out_strobe,
  output logic [N_CH*DW-1:0] o_out_sample,
  output logic o_out_dma_req,
  output logic o_out_underrun
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = DW + 8;
  localparam int FW = N_CH * DW;
  localparam logic [AW:0] LV_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] LV_HALF = (AW+1)'(DEPTH / 2);
  localparam logic [AW:0] LV_ONE = (AW+1)'(1);
  localparam logic [AW:0] LV_NEAR = (AW+1)'(DEPTH - 1);
  localparam logic [7:0] OSR_RST = SERIAL ? osd_pkg::OSR_64 : osd_pkg::OSR_128;

  typedef struct packed {
    osd_pkg::osd_run_e run;
    logic guard_en;
    osd_pkg::osd_req_e req_cond;
    logic [17:0] rate;
    logic [7:0] osr;
    logic [3:0] shift;
    logic guard_act;
    logic [8:0] cnt;
    logic [N_CH*SW-1:0] acc;
    logic dec_valid;
    logic [FW-1:0] dec_data;
    logic [31:0] samp_cnt;
    logic trig_seen;
    logic [31:0] trig_start;
    logic [DEPTH-1:0][FW-1:0] imem;
    logic [AW-1:0] iwp;
    logic [AW-1:0] irp;
    logic [AW:0] icnt;
    logic iovf;
    logic [DEPTH-1:0][FW-1:0] omem;
    logic [AW-1:0] owp;
    logic [AW-1:0] orp;
    logic [AW:0] ocnt;
    logic out_strobe;
    logic [FW-1:0] out_sample;
    logic ouf;
  } osd_state_s;

  osd_state_s q;
  osd_state_s d;

  function automatic logic [7:0] pick_osr(input logic [17:0] r);
    if (SERIAL) begin
      return osd_pkg::OSR_64;
    end
    if (r > osd_pkg::R102400) begin
      return osd_pkg::OSR_32;
    end
    if (r > osd_pkg::R51200) begin
      return osd_pkg::OSR_64;
    end
    return osd_pkg::OSR_128;
  endfunction

  function automatic logic [3:0] pick_shift(input logic [17:0] r);
    if (r < osd_pkg::R100) return osd_pkg::SH_1;
    if (r <= osd_pkg::R200) return osd_pkg::SH_256;
    if (r <= osd_pkg::R400) return osd_pkg::SH_128;
    if (r <= osd_pkg::R800) return osd_pkg::SH_64;
    if (r <= osd_pkg::R1600) return osd_pkg::SH_32;
    if (r <= osd_pkg::R3200) return osd_pkg::SH_16;
    if (r <= osd_pkg::R6400) return osd_pkg::SH_8;
    if (r <= osd_pkg::R12800) return osd_pkg::SH_4;
    if (r <= osd_pkg::R25600) return osd_pkg::SH_2;
    return osd_pkg::SH_1;
  endfunction

  logic first_w;
  logic [8:0] last_w;
  logic [N_CH*SW-1:0] sum_w;
  logic [FW-1:0] avg_w;

  assign first_w = (q.cnt == 9'h000);
  assign last_w = (9'h001 << q.shift) - 9'h001;

  // averaging over the group keeps the gain at unity for every factor
  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    logic [SW-1:0] base;
    logic signed [SW-1:0] sh;
    assign base = first_w ? '0 : q.acc[c*SW +: SW];
    assign sum_w[c*SW +: SW] = base + {{8{i_mod_data[c*DW+DW-1]}}, i_mod_data[c*DW +: DW]};
    assign sh = $signed(sum_w[c*SW +: SW]) >>> q.shift;
    assign avg_w[c*DW +: DW] = sh[DW-1:0];
  end

  logic ipush;
  logic ipop;
  logic opush;
  logic opop;
  logic in_tab;

  always_comb begin
    d = q;
    d.dec_valid = 1'b0;
    d.out_strobe = 1'b0;
    ipush = 1'b0;
    ipop = 1'b0;
    opush = 1'b0;
    opop = 1'b0;
    in_tab = (i_rate >= osd_pkg::R100) && (i_rate <= osd_pkg::R25600);
    if (i_guard_wr) begin
      d.guard_en = i_guard_en;
    end
    if (i_req_cond_wr && !SERIAL) begin
      d.req_cond = osd_pkg::osd_req_e'(i_req_cond);
    end
    // rate is only taken while idle so a running group never changes factor
    if (q.run == osd_pkg::OSD_IDLE) begin
      d.rate = i_rate;
      d.osr = pick_osr(i_rate);
      d.guard_act = in_tab && (q.guard_en || i_rate <= osd_pkg::R1000);
      d.shift = d.guard_act ? pick_shift(i_rate) : osd_pkg::SH_1;
    end
    if (i_start) begin
      d.run = osd_pkg::OSD_RUN;
      d.cnt = 9'h000;
      d.samp_cnt = 32'h00000000;
      d.trig_seen = 1'b0;
      d.iovf = 1'b0;
      d.ouf = 1'b0;
    end else if (i_stop) begin
      d.run = osd_pkg::OSD_IDLE;
    end
    if (q.run == osd_pkg::OSD_RUN && !i_start && i_mod_valid) begin
      d.acc = sum_w;
      if (q.cnt >= last_w) begin
        d.cnt = 9'h000;
        d.dec_valid = 1'b1;
        d.dec_data = avg_w;
        d.samp_cnt = q.samp_cnt + 32'h00000001;
        ipush = 1'b1;
      end else begin
        d.cnt = q.cnt + 9'h001;
      end
    end
    // index of the first sample that really belongs after the trigger
    if (q.run == osd_pkg::OSD_RUN && !i_start && i_trig && !q.trig_seen) begin
      d.trig_seen = 1'b1;
      d.trig_start = (q.samp_cnt >= FLT_DLY) ? q.samp_cnt - FLT_DLY : 32'h00000000;
    end
    ipop = i_in_ready && (q.icnt != '0);
    if (ipush && (q.icnt != LV_FULL || ipop)) begin
      d.imem[q.iwp] = avg_w;
      d.iwp = q.iwp + 1'b1;
    end else if (ipush) begin
      ipush = 1'b0;
      d.iovf = 1'b1;
    end
    if (ipop) begin
      d.irp = q.irp + 1'b1;
    end
    if (ipush && !ipop) begin
      d.icnt = q.icnt + LV_ONE;
    end else if (!ipush && ipop) begin
      d.icnt = q.icnt - LV_ONE;
    end
    opush = i_out_valid && (q.ocnt != LV_FULL);
    if (opush) begin
      d.omem[q.owp] = i_out_data;
      d.owp = q.owp + 1'b1;
    end
    if (i_out_tick && q.run == osd_pkg::OSD_RUN) begin
      if (q.ocnt != '0) begin
        opop = 1'b1;
        d.out_strobe = 1'b1;
        d.out_sample = q.omem[q.orp];
        d.orp = q.orp + 1'b1;
      end else begin
        d.ouf = 1'b1;
      end
    end
    if (opush && !opop) begin
      d.ocnt = q.ocnt + LV_ONE;
    end else if (!opush && opop) begin
      d.ocnt = q.ocnt - LV_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
      q.osr <= OSR_RST;
      q.guard_en <= GUARD_DEF;
      q.req_cond <= osd_pkg::REQ_RST;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    case (q.req_cond)
      osd_pkg::REQ_HALF: begin
        o_in_dma_req = q.icnt >= LV_HALF;
        o_out_dma_req = q.ocnt <= LV_HALF;
      end
      osd_pkg::REQ_NEAR: begin
        o_in_dma_req = q.icnt >= LV_NEAR;
        o_out_dma_req = q.ocnt <= LV_ONE;
      end
      default: begin
        o_in_dma_req = q.icnt != '0;
        o_out_dma_req = q.ocnt != LV_FULL;
      end
    endcase
  end

  assign o_mod_ratio = q.osr;
  assign o_dec_factor = 9'h001 << q.shift;
  assign o_conv_rate = {8'h00, q.rate} << q.shift;
  assign o_passband_hz = q.rate[17:1];
  assign o_alias_band_hz = q.rate;
  assign o_guard_active = q.guard_act;
  assign o_low_rate_alias_guard_enable = q.guard_en;
  assign o_dec_valid = q.dec_valid;
  assign o_dec_data = q.dec_data;
  assign o_trig_seen = q.trig_seen;
  assign o_trig_start = q.trig_start;
  assign o_in_valid = q.icnt != '0;
  assign o_in_data = q.imem[q.irp];
  assign o_in_overflow = q.iovf;
  assign o_out_ready = q.ocnt != LV_FULL;
  assign o_out_strobe = q.out_strobe;
  assign o_out_sample = q.out_sample;
  assign o_out_underrun = q.ouf;

  osr_32_band_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!SERIAL && q.run == osd_pkg::OSD_IDLE && i_rate > osd_pkg::R102400 && i_rate <= osd_pkg::R204800)
    |=> o_mod_ratio == osd_pkg::OSR_32) else $error("ratio not 32 in top band");
  osr_64_band_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!SERIAL && q.run == osd_pkg::OSD_IDLE && i_rate > osd_pkg::R51200 && i_rate <= osd_pkg::R102400)
    |=> o_mod_ratio == osd_pkg::OSR_64) else $error("ratio not 64 in mid band");
  osr_128_band_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!SERIAL && q.run == osd_pkg::OSD_IDLE && i_rate <= osd_pkg::R51200)
    |=> o_mod_ratio == osd_pkg::OSR_128) else $error("ratio not 128 in low band");
  osr_serial_a: assert property (@(posedge i_clk) disable iff (i_rst)
    SERIAL |-> o_mod_ratio == osd_pkg::OSR_64) else $error("serial ratio not fixed");
  conv_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_guard_active |-> (o_conv_rate >= 26'(osd_pkg::R25600) && o_conv_rate <= 26'(osd_pkg::R51200)))
    else $error("internal rate out of range");
  factor_one_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_guard_active |-> o_dec_factor == 9'h001) else $error("factor not one");
  dec_strobe_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (q.run == osd_pkg::OSD_RUN && !i_start && i_mod_valid && q.cnt == last_w)
    |=> o_dec_valid ##1 (o_dec_factor == 9'h001 || !o_dec_valid)) else $error("decimator strobe wrong");
  no_early_strobe_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(q.run) && o_dec_factor != 9'h001 |-> !o_dec_valid ##1 !o_dec_valid)
    else $error("strobe before group complete");
  cond_fixed_a: assert property (@(posedge i_clk) disable iff (i_rst)
    SERIAL && i_req_cond_wr |=> q.req_cond == osd_pkg::REQ_RST) else $error("request condition changed");
  req_any_a: assert property (@(posedge i_clk) disable iff (i_rst)
    q.req_cond == osd_pkg::REQ_ANY |-> o_in_dma_req == o_in_valid) else $error("input request mismatch");
  guard_default_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rst) |-> o_low_rate_alias_guard_enable == GUARD_DEF) else $error("guard default wrong");
  fifo_push_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_dec_valid && !$past(i_in_ready) && $past(o_in_valid) == 1'b0 |-> o_in_valid)
    else $error("sample not queued");
endmodule
`default_nettype wire

// ---- tb/osd_dma_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module osd_dma_host #(
  parameter int W = 96
) (
  input wire logic i_clk,
  input wire logic i_stall,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  input wire logic i_in_dma_req,
  input wire logic i_out_ready,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data
);
  logic [W-1:0] got_q[$];
  // moves input samples only while a request is raised, never ahead of it
  assign o_in_ready = i_in_dma_req && !i_stall;
  initial begin
    o_out_valid = 1'h0;
    o_out_data = '0;
  end
  always @(posedge i_clk) begin
    if (o_in_ready && i_in_valid) begin
      got_q.push_back(i_in_data);
    end
  end
  task automatic send(input logic [W-1:0] w);
    int n;
    n = 0;
    @(posedge i_clk);
    o_out_valid <= 1'h1;
    o_out_data <= w;
    do begin
      @(posedge i_clk);
      n++;
    end while (!i_out_ready && n < 50);
    o_out_valid <= 1'h0;
    // released bus carries the inverted word so stale data never matches
    o_out_data <= ~w;
  endtask
endmodule
`default_nettype wire

// ---- tb/osd_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module osd_top_test;
  localparam int W = 96;
  localparam logic [17:0] RT[17] = '{osd_pkg::R100, osd_pkg::R200, osd_pkg::R200 + 18'h1, osd_pkg::R400,
    osd_pkg::R800, osd_pkg::R800 + 18'h1, osd_pkg::R1600, osd_pkg::R3200, osd_pkg::R6400, osd_pkg::R12800,
    osd_pkg::R25600, osd_pkg::R25600 + 18'h1, osd_pkg::R51200, osd_pkg::R51200 + 18'h1, osd_pkg::R102400,
    osd_pkg::R102400 + 18'h1, osd_pkg::R204800};
  localparam logic [8:0] FT[17] = '{9'h100, 9'h100, 9'h080, 9'h080, 9'h040, 9'h020, 9'h020, 9'h010, 9'h008,
    9'h004, 9'h002, 9'h001, 9'h001, 9'h001, 9'h001, 9'h001, 9'h001};
  localparam logic [7:0] MT[17] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80,
    8'h80, 8'h80, 8'h80, 8'h40, 8'h40, 8'h20, 8'h20};
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [17:0] i_rate = 18'h00064;
  logic i_guard_wr = 1'h0, i_guard_en = 1'h0, i_req_cond_wr = 1'h0, i_start = 1'h0, i_stop = 1'h0;
  logic i_trig = 1'h0, i_mod_valid = 1'h0, i_out_tick = 1'h0, stall = 1'h0;
  logic [1:0] i_req_cond = 2'h0;
  logic [W-1:0] i_mod_data = '0;
  logic [7:0] o_mod_ratio;
  logic [8:0] o_dec_factor;
  logic [25:0] o_conv_rate;
  logic [16:0] o_passband_hz;
  logic [17:0] o_alias_band_hz;
  logic [31:0] o_trig_start;
  logic o_guard_active, o_low_rate_alias_guard_enable, o_dec_valid, o_trig_seen, o_in_valid, i_in_ready;
  logic o_in_dma_req, o_in_overflow, i_out_valid, o_out_ready, o_out_strobe, o_out_dma_req, o_out_underrun;
  logic [W-1:0] o_dec_data, o_in_data, i_out_data, o_out_sample;
  logic [W-1:0] dec_q[$];
  int err_total = 0;
  int n_checks = 0;
  always #4 i_clk = ~i_clk;
  osd_top osd_top_inst (.i_clk, .i_rst, .i_rate, .i_guard_wr, .i_guard_en, .i_req_cond_wr, .i_req_cond,
    .i_start, .i_stop, .i_trig, .i_mod_valid, .i_mod_data, .o_mod_ratio, .o_dec_factor, .o_conv_rate,
    .o_passband_hz, .o_alias_band_hz, .o_guard_active, .o_low_rate_alias_guard_enable, .o_dec_valid,
    .o_dec_data, .o_trig_seen, .o_trig_start, .o_in_valid, .o_in_data, .i_in_ready, .o_in_dma_req,
    .o_in_overflow, .i_out_valid, .i_out_data, .o_out_ready, .i_out_tick, .o_out_strobe, .o_out_sample,
    .o_out_dma_req, .o_out_underrun);
  osd_dma_host #(.W(W)) osd_dma_host_inst (.i_clk(i_clk), .i_stall(stall), .i_in_valid(o_in_valid),
    .i_in_data(o_in_data), .i_in_dma_req(o_in_dma_req), .i_out_ready(o_out_ready), .o_in_ready(i_in_ready),
    .o_out_valid(i_out_valid), .o_out_data(i_out_data));
  always @(posedge i_clk) begin
    if (o_dec_valid === 1'h1) begin
      dec_q.push_back(o_dec_data);
    end
  end
  function automatic logic [W-1:0] fv(input int k);
    return {4{24'(k * 100 - 250)}};
  endfunction
  task automatic chk(input string nm, input logic [W-1:0] seen, input logic [W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic set_rate(input logic [17:0] r);
    @(posedge i_clk);
    i_rate <= r;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic set_cond(input logic [1:0] c);
    @(posedge i_clk);
    i_req_cond_wr <= 1'h1;
    i_req_cond <= c;
    @(posedge i_clk);
    i_req_cond_wr <= 1'h0;
  endtask
  task automatic pulse_start();
    @(posedge i_clk);
    i_stop <= 1'h0;
    i_start <= 1'h1;
  endtask
  task automatic frames(input int n, input int trig_at);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      i_start <= 1'h0;
      i_mod_valid <= 1'h1;
      i_mod_data <= fv(k);
      i_trig <= (k == trig_at);
    end
    @(posedge i_clk);
    i_mod_valid <= 1'h0;
    i_trig <= 1'h0;
    i_stop <= 1'h1;
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (osd_dma_host_inst.got_q.size() < n && k < 200) begin
      @(posedge i_clk);
      k++;
    end
    if (osd_dma_host_inst.got_q.size() < n) begin
      err_total++;
      $display("Error drain timeout");
      finish_test();
    end
    #1;
  endtask
  task automatic t_reset();
    chk("ratio", o_mod_ratio, 8'h80);
    chk("factor", o_dec_factor, 9'h001);
    chk("guard_en", o_low_rate_alias_guard_enable, 1'h1);
    chk("out_req", o_out_dma_req, 1'h1);
  endtask
  task automatic t_table();
    for (int i = 0; i < 17; i++) begin
      set_rate(RT[i]);
      chk("ratio", o_mod_ratio, MT[i]);
      chk("factor", o_dec_factor, FT[i]);
      chk("conv", o_conv_rate, 26'(RT[i]) * 26'(FT[i]));
      chk("active", o_guard_active, FT[i] != 9'h001);
      chk("pass", o_passband_hz, RT[i] >> 1);
      chk("band", o_alias_band_hz, RT[i]);
    end
  endtask
  task automatic t_guard_off();
    @(posedge i_clk);
    i_guard_wr <= 1'h1;
    @(posedge i_clk);
    i_guard_wr <= 1'h0;
    set_rate(osd_pkg::R3200);
    chk("guard_en", o_low_rate_alias_guard_enable, 1'h0);
    chk("factor", o_dec_factor, 9'h001);
    set_rate(osd_pkg::R800);
    chk("factor", o_dec_factor, 9'h040);
    @(posedge i_clk);
    i_guard_en <= 1'h1;
    i_guard_wr <= 1'h1;
    @(posedge i_clk);
    i_guard_wr <= 1'h0;
  endtask
  task automatic t_decim();
    set_rate(osd_pkg::R12800);
    dec_q.delete();
    osd_dma_host_inst.got_q.delete();
    pulse_start();
    frames(8, 2);
    wait_got(2);
    chk("dec_count", dec_q.size(), 2);
    chk("dec0", dec_q[0], {4{24'hffff9c}});
    chk("dec1", dec_q[1], {4{24'h00012c}});
    chk("fifo0", osd_dma_host_inst.got_q[0], {4{24'hffff9c}});
    chk("trig_seen", o_trig_seen, 1'h1);
    chk("trig_start", o_trig_start, 32'h0);
  endtask
  task automatic t_overflow();
    set_rate(osd_pkg::R51200);
    osd_dma_host_inst.got_q.delete();
    set_cond(2'h2);
    stall <= 1'h1;
    pulse_start();
    frames(80, 70);
    chk("overflow", o_in_overflow, 1'h1);
    chk("req_near", o_in_dma_req, 1'h1);
    chk("out_req_near", o_out_dma_req, 1'h1);
    chk("trig_late", o_trig_start, 32'h00000046 - osd_pkg::FLT_DLY);
    @(posedge i_clk);
    stall <= 1'h0;
    wait_got(2);
    repeat (3) @(posedge i_clk);
    #1;
    chk("got_near", osd_dma_host_inst.got_q.size(), 2);
    set_cond(2'h1);
    wait_got(9);
    repeat (3) @(posedge i_clk);
    #1;
    chk("got_half", osd_dma_host_inst.got_q.size(), 9);
    set_cond(2'h0);
    wait_got(16);
    chk("req_empty", o_in_dma_req, 1'h0);
    chk("last", osd_dma_host_inst.got_q[15], fv(15));
  endtask
  task automatic t_out();
    osd_dma_host_inst.send(fv(7));
    pulse_start();
    @(posedge i_clk);
    i_start <= 1'h0;
    i_out_tick <= 1'h1;
    @(posedge i_clk);
    i_out_tick <= 1'h0;
    #1;
    chk("strobe", o_out_strobe, 1'h1);
    chk("sample", o_out_sample, fv(7));
    chk("in_kept", o_in_valid, 1'h0);
    chk("out_ready", o_out_ready, 1'h1);
    @(posedge i_clk);
    i_out_tick <= 1'h1;
    @(posedge i_clk);
    i_out_tick <= 1'h0;
    @(posedge i_clk);
    #1;
    chk("underrun", o_out_underrun, 1'h1);
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    #1;
    t_reset();
    repeat (2) @(posedge i_clk);
    i_rst <= 1'h0;
    t_table();
    t_guard_off();
    t_decim();
    t_overflow();
    t_out();
    finish_test();
  end
endmodule
`default_nettype wire
